// file: hbfp_pkg.sv
/*
 * Package for the half-bridge fault protection block: widths, global
 * status bit positions, reset values and timing counts.
 * Assumes a 200 MHz logic clock.
 */
package hbfp_pkg;
	localparam int HBFP_BRIDGES = 10;
	localparam int HBFP_CLK_MHZ = 200;
	// Global status bit positions
	localparam int HBFP_GS_TPW = 1;
	localparam int HBFP_GS_TSD = 2;
	localparam int HBFP_GS_OV = 4;
	localparam int HBFP_GS_UV = 5;
	localparam int HBFP_GS_LE = 6;
	localparam logic [7:0] HBFP_GS_RESET = 8'h00;
	// Timing figures in ns, with derived cycle counts (minimums round up)
	localparam int HBFP_OC_FILTER_NS = 10000;
	localparam int HBFP_OC_FILTER_CYC = (HBFP_OC_FILTER_NS * HBFP_CLK_MHZ + 999) / 1000;
	localparam int HBFP_DEAD_HL_NS = 200;
	localparam int HBFP_DEAD_HL_CYC = (HBFP_DEAD_HL_NS * HBFP_CLK_MHZ + 999) / 1000;
	localparam int HBFP_DEAD_LH_NS = 200;
	localparam int HBFP_DEAD_LH_CYC = (HBFP_DEAD_LH_NS * HBFP_CLK_MHZ + 999) / 1000;
	localparam int HBFP_OL_FILTER_NS = 2000;
	localparam int HBFP_OL_FILTER_CYC = (HBFP_OL_FILTER_NS * HBFP_CLK_MHZ + 999) / 1000;
	localparam int HBFP_OL_LED_NS = 500;
	localparam int HBFP_OL_LED_CYC = (HBFP_OL_LED_NS * HBFP_CLK_MHZ + 999) / 1000;
	localparam int HBFP_CNT_W = 16;
	// Output drive state of one half-bridge
	typedef enum logic [1:0]
	{
		HBFP_OFF = 2'b00,
		HBFP_HIGH = 2'b01,
		HBFP_DEAD = 2'b11,
		HBFP_LOW = 2'b10
	} hbfp_drive_t;
endpackage

// file: hbfp_leg.sv
/*
 * One half-bridge: per-switch overcurrent and open-load filters and
 * latches, and the dead-time sequencer that drives the two gates.
 * Assumes fault inputs are clean logic levels synchronous to clk.
 */
`timescale 1ns/1ps
module hbfp_leg
	import hbfp_pkg::*;
#(
	parameter int OC_CYC = HBFP_OC_FILTER_CYC,
	parameter int HL_CYC = HBFP_DEAD_HL_CYC,
	parameter int LH_CYC = HBFP_DEAD_LH_CYC,
	parameter int OL_CYC = HBFP_OL_FILTER_CYC,
	parameter int OL_LED_CYC = HBFP_OL_LED_CYC
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic high_switch_enable,
	input wire logic low_switch_enable,
	input wire logic global_off,
	input wire logic low_current_sel,
	input wire logic oc_high_in,
	input wire logic oc_low_in,
	input wire logic ol_high_in,
	input wire logic ol_low_in,
	input wire logic ol_high_led_in,
	input wire logic clr_oc_high,
	input wire logic clr_oc_low,
	input wire logic clr_ol_high,
	input wire logic clr_ol_low,
	output logic high_overcurrent_bit,
	output logic low_overcurrent_bit,
	output logic high_openload_bit,
	output logic low_openload_bit,
	output logic gate_high,
	output logic gate_low
);
	hbfp_drive_t state;
	hbfp_drive_t next_state;
	logic [HBFP_CNT_W-1:0] oc_h_cnt, oc_l_cnt, ol_h_cnt, ol_l_cnt, dead_cnt;
	logic want_high, want_low, dead_done, ol_h_raw, ol_h_limit_hit;
	logic [HBFP_CNT_W-1:0] ol_h_limit;

	// A tripped switch stays off while its bit is set; globals force all off
	assign want_high = high_switch_enable && !high_overcurrent_bit && !global_off;
	assign want_low = low_switch_enable && !low_overcurrent_bit && !global_off && !want_high;
	assign dead_done = (dead_cnt == '0);
	// LED mode picks the lower threshold comparator and shorter filter
	assign ol_h_raw = low_current_sel ? ol_high_led_in : ol_high_in;
	assign ol_h_limit = low_current_sel ? HBFP_CNT_W'(OL_LED_CYC) : HBFP_CNT_W'(OL_CYC);
	assign ol_h_limit_hit = (ol_h_cnt >= ol_h_limit - HBFP_CNT_W'(1));

	// Drive sequencer: every change of side passes through DEAD
	always_comb
	begin
		next_state = state;
		case (state)
			HBFP_OFF:
				if (want_high || want_low)
					next_state = HBFP_DEAD;
			HBFP_HIGH:
				if (!want_high)
					next_state = want_low ? HBFP_DEAD : HBFP_OFF;
			HBFP_LOW:
				if (!want_low)
					next_state = want_high ? HBFP_DEAD : HBFP_OFF;
			HBFP_DEAD:
				if (!want_high && !want_low)
					next_state = HBFP_OFF;
				else if (dead_done)
					next_state = want_high ? HBFP_HIGH : HBFP_LOW;
			default:
				next_state = HBFP_OFF;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			state <= HBFP_OFF;
		else
			state <= next_state;
	end

	// Dead-time counter reloads on entry to DEAD; length follows direction
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			dead_cnt <= '0;
		else if (next_state == HBFP_DEAD && state != HBFP_DEAD)
			dead_cnt <= want_high ? HBFP_CNT_W'(LH_CYC - 1) : HBFP_CNT_W'(HL_CYC - 1);
		else if (!dead_done)
			dead_cnt <= dead_cnt - HBFP_CNT_W'(1);
	end

	// Gates come straight from flops; never both on
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gate_high <= 1'b0;
			gate_low <= 1'b0;
		end
		else
		begin
			gate_high <= (next_state == HBFP_HIGH) && want_high;
			gate_low <= (next_state == HBFP_LOW) && want_low;
		end
	end

	// Overcurrent filters restart whenever the condition drops
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			oc_h_cnt <= '0;
			oc_l_cnt <= '0;
		end
		else
		begin
			oc_h_cnt <= (oc_high_in && gate_high) ? oc_h_cnt + HBFP_CNT_W'(1) : '0;
			oc_l_cnt <= (oc_low_in && gate_low) ? oc_l_cnt + HBFP_CNT_W'(1) : '0;
		end
	end

	// Open-load filters only run on an active switch
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ol_h_cnt <= '0;
			ol_l_cnt <= '0;
		end
		else
		begin
			ol_h_cnt <= (ol_h_raw && gate_high && !ol_h_limit_hit) ? ol_h_cnt + HBFP_CNT_W'(1)
				: ((ol_h_raw && gate_high) ? ol_h_cnt : '0);
			ol_l_cnt <= (ol_low_in && gate_low && ol_l_cnt < HBFP_CNT_W'(OL_CYC - 1))
				? ol_l_cnt + HBFP_CNT_W'(1) : ((ol_low_in && gate_low) ? ol_l_cnt : '0);
		end
	end

	// Latches: hardware set wins over a host clear in the same cycle
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			high_overcurrent_bit <= 1'b0;
			low_overcurrent_bit <= 1'b0;
			high_openload_bit <= 1'b0;
			low_openload_bit <= 1'b0;
		end
		else
		begin
			high_overcurrent_bit <= (oc_h_cnt >= HBFP_CNT_W'(OC_CYC - 1) && oc_high_in && gate_high)
				|| (high_overcurrent_bit && !clr_oc_high);
			low_overcurrent_bit <= (oc_l_cnt >= HBFP_CNT_W'(OC_CYC - 1) && oc_low_in && gate_low)
				|| (low_overcurrent_bit && !clr_oc_low);
			high_openload_bit <= (ol_h_limit_hit && ol_h_raw && gate_high)
				|| (high_openload_bit && !clr_ol_high);
			low_openload_bit <= (ol_l_cnt >= HBFP_CNT_W'(OL_CYC - 1) && ol_low_in && gate_low)
				|| (low_openload_bit && !clr_ol_low);
		end
	end
endmodule

// file: hbfp_top.sv
/*
 * Fault protection top for a ten half-bridge driver: global supply and
 * thermal flags, load-error summary, and one hbfp_leg per half-bridge.
 * Assumes the SPI front end delivers one-cycle clear pulses and the
 * enable bits as levels; rst_n covers enable-pin and logic-supply reset.
 */
`timescale 1ns/1ps
// Summary of operation
// - LED select on high side one or two uses lower threshold, shorter filter.
// - Any overcurrent or open-load sets and holds load-error summary, bit 6.
// - After overcurrent filter expires, switch latched off and its overcurrent bit set.
// - Tripped switch stays off while its bit is set; enables untouched.
// - Separate overcurrent bit per high and low switch of every bridge.
// - Separate open-load bit per switch; open load never changes outputs.
// - Thermal warning latched at bit 1; outputs unaffected.
// - Thermal shutdown latched at bit 2; all off until host clears.
// - Supply undervoltage latched at bit 5; outputs return when supply recovers.
// - Supply overvoltage latched at bit 4; outputs return when supply recovers.
// - High and low switch of one bridge never on together.
// - Dead time between one switch off and the other on, per direction.
// - Device never clears flags itself; host clears them.
module hbfp_top
	import hbfp_pkg::*;
#(
	parameter int BRIDGES = HBFP_BRIDGES,
	parameter int OC_CYC = HBFP_OC_FILTER_CYC
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [BRIDGES-1:0] high_switch_enable,
	input wire logic [BRIDGES-1:0] low_switch_enable,
	input wire logic low_current_select_first_high,
	input wire logic low_current_select_second_high,
	input wire logic [BRIDGES-1:0] oc_high_detect,
	input wire logic [BRIDGES-1:0] oc_low_detect,
	input wire logic [BRIDGES-1:0] ol_high_detect,
	input wire logic [BRIDGES-1:0] ol_low_detect,
	input wire logic [1:0] ol_high_led_detect,
	input wire logic temp_warning_detect,
	input wire logic temp_shutdown_detect,
	input wire logic supply_under_detect,
	input wire logic supply_over_detect,
	input wire logic [BRIDGES-1:0] clear_high_overcurrent,
	input wire logic [BRIDGES-1:0] clear_low_overcurrent,
	input wire logic [BRIDGES-1:0] clear_high_openload,
	input wire logic [BRIDGES-1:0] clear_low_openload,
	input wire logic [7:0] clear_global_status,
	output logic [7:0] global_status_first,
	output logic [BRIDGES-1:0] high_overcurrent_bit,
	output logic [BRIDGES-1:0] low_overcurrent_bit,
	output logic [BRIDGES-1:0] high_openload_bit,
	output logic [BRIDGES-1:0] low_openload_bit,
	output logic [BRIDGES-1:0] gate_high,
	output logic [BRIDGES-1:0] gate_low
);
	logic global_off;
	logic any_load_fault;
	logic [7:0] next_status;
	logic [7:0] status_set;

	// Supply flags force off only while the condition lasts; thermal until cleared
	assign global_off = supply_under_detect || supply_over_detect
		|| global_status_first[HBFP_GS_TSD] || temp_shutdown_detect;
	// The summary is driven from the per-switch latches, so it sees every new trip
	assign any_load_fault = |{high_overcurrent_bit, low_overcurrent_bit,
		high_openload_bit, low_openload_bit};

	// Set terms per global bit; a warning has no effect on the outputs
	always_comb
	begin
		status_set = HBFP_GS_RESET;
		status_set[HBFP_GS_TPW] = temp_warning_detect;
		status_set[HBFP_GS_TSD] = temp_shutdown_detect;
		status_set[HBFP_GS_OV] = supply_over_detect;
		status_set[HBFP_GS_UV] = supply_under_detect;
		status_set[HBFP_GS_LE] = any_load_fault;
	end

	// Set wins over clear; nothing but a host clear drops a bit
	assign next_status = status_set | (global_status_first & ~clear_global_status);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			global_status_first <= HBFP_GS_RESET;
		else
			global_status_first <= next_status;
	end

	// One leg per bridge; only the first two high sides have the LED option
	genvar g;
	generate
		for (g = 0; g < BRIDGES; g++)
		begin : g_leg
			logic led_sel;
			logic led_det;
			assign led_sel = (g == 0) ? low_current_select_first_high
				: ((g == 1) ? low_current_select_second_high : 1'b0);
			assign led_det = (g < 2) ? ol_high_led_detect[(g < 2) ? g : 0] : 1'b0;
			hbfp_leg #(
				.OC_CYC(OC_CYC)
			) u_leg (
				.clk(clk),
				.rst_n(rst_n),
				.high_switch_enable(high_switch_enable[g]),
				.low_switch_enable(low_switch_enable[g]),
				.global_off(global_off),
				.low_current_sel(led_sel),
				.oc_high_in(oc_high_detect[g]),
				.oc_low_in(oc_low_detect[g]),
				.ol_high_in(ol_high_detect[g]),
				.ol_low_in(ol_low_detect[g]),
				.ol_high_led_in(led_det),
				.clr_oc_high(clear_high_overcurrent[g]),
				.clr_oc_low(clear_low_overcurrent[g]),
				.clr_ol_high(clear_high_openload[g]),
				.clr_ol_low(clear_low_openload[g]),
				.high_overcurrent_bit(high_overcurrent_bit[g]),
				.low_overcurrent_bit(low_overcurrent_bit[g]),
				.high_openload_bit(high_openload_bit[g]),
				.low_openload_bit(low_openload_bit[g]),
				.gate_high(gate_high[g]),
				.gate_low(gate_low[g])
			);
		end
	endgenerate
endmodule

// file: hbfp_host.sv
/* Host model: one-cycle clear pulses for latched flags.
   Assumes calls come from a process in step with clk. */
`timescale 1ns/1ps
module hbfp_host
	import hbfp_pkg::*;
(
	input wire logic clk,
	output logic [HBFP_BRIDGES-1:0] clear_high_overcurrent,
	output logic [HBFP_BRIDGES-1:0] clear_low_overcurrent,
	output logic [HBFP_BRIDGES-1:0] clear_high_openload,
	output logic [HBFP_BRIDGES-1:0] clear_low_openload,
	output logic [7:0] clear_global_status
);
	initial
	begin
		{clear_high_overcurrent, clear_low_overcurrent} = '0;
		{clear_high_openload, clear_low_openload, clear_global_status} = '0;
	end
	// Pulse lasts one cycle; the device never clears a flag by itself
	task automatic clr(input int k, input int i);
		@(posedge clk);
		case (k)
			0: clear_high_overcurrent[i] <= 1'b1;
			1: clear_low_overcurrent[i] <= 1'b1;
			2: clear_high_openload[i] <= 1'b1;
			3: clear_low_openload[i] <= 1'b1;
			default: clear_global_status[i] <= 1'b1;
		endcase
		@(posedge clk);
		{clear_high_overcurrent, clear_low_overcurrent} <= '0;
		{clear_high_openload, clear_low_openload, clear_global_status} <= '0;
	endtask
endmodule

// file: hbfp_top_assertions.sv
/* Checker for the fault protection top: cross current, trips, flag latching.
   Assumes it is bound to hbfp_top and sees only its ports. */
`timescale 1ns/1ps
module hbfp_top_assertions
	import hbfp_pkg::*;
#(
	parameter int BRIDGES = HBFP_BRIDGES
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic supply_under_detect,
	input wire logic [7:0] clear_global_status,
	input wire logic [BRIDGES-1:0] clear_high_overcurrent,
	input wire logic [7:0] global_status_first,
	input wire logic [BRIDGES-1:0] high_overcurrent_bit,
	input wire logic [BRIDGES-1:0] low_overcurrent_bit,
	input wire logic [BRIDGES-1:0] gate_high,
	input wire logic [BRIDGES-1:0] gate_low
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire [BRIDGES-1:0] gates_on;
	// Any switch conducting
	assign gates_on = gate_high | gate_low;
	no_cross_a: assert property ((gate_high & gate_low) == '0)
		else $error("both switches of one bridge on");
	dead_gap_a: assert property ($fell(gate_low[0]) |-> !gate_high[0] [*8])
		else $error("high side on without dead time");
	dead_gap_low_a: assert property ($fell(gate_high[0]) |-> !gate_low[0] [*8])
		else $error("low side on without dead time");
	oc_off_a: assert property (
		(($past(high_overcurrent_bit) & gate_high) | ($past(low_overcurrent_bit) & gate_low)) == '0)
		else $error("tripped switch still on");
	load_err_a: assert property (
		(high_overcurrent_bit | low_overcurrent_bit) != '0 |=> global_status_first[HBFP_GS_LE])
		else $error("load error not set");
	tsd_off_a: assert property (
		global_status_first[HBFP_GS_TSD] && $past(global_status_first[HBFP_GS_TSD])
		|-> gates_on == '0)
		else $error("output on during thermal shutdown");
	uv_off_a: assert property (
		supply_under_detect [*2] |=> global_status_first[HBFP_GS_UV] && gates_on == '0)
		else $error("output on during undervoltage");
	gs_hold_a: assert property (
		($past(global_status_first) & ~global_status_first & ~$past(clear_global_status)) == '0)
		else $error("global flag dropped without clear");
	oc_hold_a: assert property (
		($past(high_overcurrent_bit) & ~high_overcurrent_bit & ~$past(clear_high_overcurrent)) == '0)
		else $error("overcurrent flag dropped without clear");
endmodule
bind hbfp_top hbfp_top_assertions #(.BRIDGES(BRIDGES)) hbfp_top_assertions_inst (
	.clk(clk), .rst_n(rst_n), .supply_under_detect(supply_under_detect),
	.clear_global_status(clear_global_status), .clear_high_overcurrent(clear_high_overcurrent),
	.global_status_first(global_status_first), .high_overcurrent_bit(high_overcurrent_bit),
	.low_overcurrent_bit(low_overcurrent_bit), .gate_high(gate_high), .gate_low(gate_low));

// file: hbfp_top_tb.sv
/* Bench: drives enables and detectors, host model clears flags.
   Assumes a short overcurrent filter of OC cycles. */
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
	$display("wrong value at %0t: %h, expected %h", $time, (a), (b)); end end
`define WAITC(c, lim) begin n = 0; while (!(c) && n < (lim)) begin tick(1); n++; end \
	if (!(c)) error_cnt++; end
module hbfp_top_tb
	import hbfp_pkg::*;
;
	localparam int B = HBFP_BRIDGES;
	localparam int OC = 8;
	logic clk, rst_n, sel0, sel1;
	logic [B-1:0] hen, len, och, ocl, olh, oll, clr_ohc, clr_olc, clr_hol, clr_lol;
	logic [1:0] led;
	logic [3:0] env;
	logic [7:0] clr_gs, gs;
	logic [B-1:0] hoc, loc, hol, lol, gh, gl;
	int error_cnt = 0;
	int samples_checked = 0;
	int n;
	int gs_bit[4] = '{HBFP_GS_TPW, HBFP_GS_TSD, HBFP_GS_UV, HBFP_GS_OV};
	hbfp_host hbfp_host_inst (.clk(clk), .clear_high_overcurrent(clr_ohc),
		.clear_low_overcurrent(clr_olc), .clear_high_openload(clr_hol),
		.clear_low_openload(clr_lol), .clear_global_status(clr_gs));
	hbfp_top #(.OC_CYC(OC)) hbfp_top_inst (.clk(clk), .rst_n(rst_n),
		.high_switch_enable(hen), .low_switch_enable(len),
		.low_current_select_first_high(sel0), .low_current_select_second_high(sel1),
		.oc_high_detect(och), .oc_low_detect(ocl), .ol_high_detect(olh), .ol_low_detect(oll),
		.ol_high_led_detect(led), .temp_warning_detect(env[0]), .temp_shutdown_detect(env[1]),
		.supply_under_detect(env[2]), .supply_over_detect(env[3]),
		.clear_high_overcurrent(clr_ohc), .clear_low_overcurrent(clr_olc),
		.clear_high_openload(clr_hol), .clear_low_openload(clr_lol),
		.clear_global_status(clr_gs), .global_status_first(gs), .high_overcurrent_bit(hoc),
		.low_overcurrent_bit(loc), .high_openload_bit(hol), .low_openload_bit(lol),
		.gate_high(gh), .gate_low(gl));
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Sample 1 ns after the edge so register updates have landed
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// The run needs about 1900 cycles; 20000 means a hang
	initial
	begin
		#100000;
		error_cnt++;
		give_verdict();
	end
	initial
	begin
		rst_n = 1'b0;
		{hen, len, och, ocl, olh, oll, sel0, sel1, led, env} = '0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		tick(1);
		`CHK({gs, gh, gl}, 28'h0)
		$display("test reset done");
		// Each switch-on waits out the dead time
		@(posedge clk) hen[0] <= 1'b1;
		`WAITC(gh[0], 60)
		`CHK(n > 39 && n < 44, 1'b1)
		@(posedge clk) {hen[0], len[0]} <= 2'b01;
		`WAITC(gl[0], 60)
		`CHK(n > 39 && n < 44, 1'b1)
		$display("test dead time done");
		// Short on the low side: trip, retrip after a clear, then recover
		@(posedge clk) ocl[0] <= 1'b1;
		`WAITC(loc[0], 30)
		`CHK(n < OC + 4, 1'b1)
		tick(2);
		`CHK({gl[0], gs[HBFP_GS_LE], len[0], hoc[0]}, 4'h6)
		hbfp_host_inst.clr(1, 0);
		tick(2);
		`CHK(loc[0], 1'b0)
		`WAITC(loc[0], 100)
		`CHK(loc[0], 1'b1)
		@(posedge clk) ocl[0] <= 1'b0;
		hbfp_host_inst.clr(1, 0);
		tick(2);
		`WAITC(gl[0], 60)
		`CHK({gl[0], loc[0]}, 2'b10)
		$display("test overcurrent done");
		// Open load flags only; LED select shortens the filter
		@(posedge clk) len[1] <= 1'b1;
		`WAITC(gl[1], 60)
		@(posedge clk) oll[1] <= 1'b1;
		`WAITC(lol[1], 500)
		`CHK({n > 390, gl[1], gs[HBFP_GS_LE]}, 3'b111)
		@(posedge clk) hen[0] <= 1'b1;
		@(posedge clk) sel0 <= 1'b1;
		`WAITC(gh[0], 60)
		@(posedge clk) led[0] <= 1'b1;
		`WAITC(hol[0], 500)
		`CHK({n < 110, gh[0]}, 2'b11)
		@(posedge clk) {oll[1], led[0]} <= 2'b00;
		hbfp_host_inst.clr(2, 0);
		hbfp_host_inst.clr(3, 1);
		hbfp_host_inst.clr(4, HBFP_GS_LE);
		tick(2);
		`CHK({hol[0], lol[1], gs}, 10'h000)
		$display("test open load done");
		// Warning keeps outputs, shutdown needs a clear, supply faults recover alone
		for (int k = 0; k < 4; k++)
		begin
			@(posedge clk) env[k] <= 1'b1;
			tick(4);
			`CHK({gs[gs_bit[k]], gh[0]}, {1'b1, k == 0})
			@(posedge clk) env[k] <= 1'b0;
			tick(46);
			`CHK({gs[gs_bit[k]], gh[0]}, {1'b1, k != 1})
			hbfp_host_inst.clr(4, gs_bit[k]);
			tick(46);
			`CHK({gs[gs_bit[k]], gh[0]}, 2'b01)
		end
		$display("test global flags done");
		// High-side trip after a cut filter run, then the second LED select
		@(posedge clk) och[0] <= 1'b1;
		repeat (OC - 2) @(posedge clk);
		och[0] <= 1'b0;
		@(posedge clk) och[0] <= 1'b1;
		`WAITC(hoc[0], 30)
		`CHK(n, OC)
		tick(2);
		`CHK({gh[0], hoc[0], loc[0], gs[HBFP_GS_LE]}, 4'b0101)
		`WAITC(gl[0], 60)
		`CHK({gl[0], gh[0], n > 35}, 3'b101)
		@(posedge clk) och[0] <= 1'b0;
		hbfp_host_inst.clr(0, 0);
		`WAITC(gh[0], 60)
		`CHK({gh[0], gl[0], hoc[0]}, 3'b100)
		@(posedge clk) {hen[1], sel0} <= 2'b10;
		@(posedge clk) sel1 <= 1'b1;
		`WAITC(gh[1], 60)
		@(posedge clk) {olh[1], led[1]} <= 2'b11;
		`WAITC(hol[1], 500)
		`CHK({n == HBFP_OL_LED_CYC, gh[1], gl[1]}, 3'b110)
		@(posedge clk) {olh[1], led[1], sel1} <= 3'b000;
		hbfp_host_inst.clr(2, 1);
		@(posedge clk) {olh[1], led[1]} <= 2'b11;
		`WAITC(hol[1], 500)
		`CHK({n == HBFP_OL_FILTER_CYC, gh[1]}, 2'b11)
		@(posedge clk) {olh[1], led[1]} <= 2'b00;
		hbfp_host_inst.clr(2, 1);
		hbfp_host_inst.clr(4, HBFP_GS_LE);
		tick(2);
		`CHK({hol[1], hoc[0], gs}, 10'h000)
		$display("test high side done");
		give_verdict();
	end
endmodule
